// File: core/sfr_core.sv
// Retransmit FIFO control: pin sampling, offsets, flags, mailboxes and buffer
// How it works
// - Mailbox-2 write by port B drops its flag
// - Port-A mailbox read raises mailbox-2 flag
// - Reset leaves mailbox-2 flag high
// - Output-ready low when empty, reads ignored
// - Output-ready rises on third port-B edge
// - Read-from-marker reloads marked word
// - Retransmit select with ready data marks word
// - Mark holds until retransmit select low
// - Port A: high writes, low reads
// - Port B: low writes, high reads
// - Reset pin may change any time
// - Reset clears pointers and sets flags
// - Input-ready rises two port-A edges later
// - Offset method latched at reset release
// - Presets load both offsets automatically
// - First two parallel writes load Y, X
// - Parallel offsets from data bits 10..0
// - Serial bits shift Y MSB first
// - Serial mode holds input-ready until done
// - Mailbox-1 flag set and cleared likewise
// - Mailbox select steers port to mailboxes
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ------------------------------------------------------------------
module sfr_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] lvlOut,
  output logic      [W-1:0] riseOut
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q;
  // A change counts only once the two later stages agree
  wire  [W-1:0] lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      {s1_q, s2_q, s3_q} <= '0;
      lvl_q              <= '0;
      rise_q             <= '0;
    end else begin
      s1_q   <= pinIn;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= lvl_d & ~lvl_q;
    end
  end
  assign lvlOut  = lvl_q;
  assign riseOut = rise_q;
endmodule : sfr_sync

// ------------------------------------------------------------------
// Data buffer with retransmit mark
// ------------------------------------------------------------------
module sfr_buffer #(
  parameter int W     = 36,
  parameter int DEPTH = 16,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [W-1:0]     inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [W-1:0]     outData,
  input  wire logic             markSet,
  input  wire logic             markClr,
  input  wire logic             rewind,
  output logic      [W-1:0]     markData,
  output logic      [CNT_W-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW:0]   wrPtr_q, rdPtr_q, markPtr_q;
  logic          marked_q;
  // While marked, the marked word and all after it stay protected
  wire  [AW:0]   basePtr = marked_q ? markPtr_q : rdPtr_q;
  wire  [AW:0]   used    = wrPtr_q - basePtr;
  wire           push    = inValid & inReady;
  wire           pop     = outValid & outReady & ~rewind;

  assign inReady  = used != (AW + 1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem_q[rdPtr_q[AW-1:0]];
  assign markData = mem_q[markPtr_q[AW-1:0]];
  assign count    = CNT_W'(wrPtr_q - rdPtr_q);

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr_q   <= '0;
      rdPtr_q   <= '0;
      markPtr_q <= '0;
      marked_q  <= 1'b0;
    end else begin
      wrPtr_q <= wrPtr_q + (AW + 1)'(push);
      if (rewind) begin
        rdPtr_q <= markPtr_q + (AW + 1)'(1);
      end else begin
        rdPtr_q <= rdPtr_q + (AW + 1)'(pop);
      end
      if (markSet) begin
        markPtr_q <= rdPtr_q - (AW + 1)'(1);
        marked_q  <= 1'b1;
      end else if (markClr) begin
        marked_q <= 1'b0;
      end
    end
  end
endmodule : sfr_buffer

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module sfr_core import sfr_pkg::*; #(
  parameter int DEPTH     = 512,
  parameter int BUF_DEPTH = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              resetPinN,
  input  wire logic              portAClock,
  input  wire logic              portBClock,
  input  wire logic              portASelectN,
  input  wire logic              portAEnable,
  input  wire logic              portAWriteReadSelect,
  input  wire logic              portAMailboxSelect,
  input  wire logic [DATA_W-1:0] portADataIn,
  input  wire logic              portBSelectN,
  input  wire logic              portBEnable,
  input  wire logic              portBWriteReadSelect,
  input  wire logic              portBMailboxSelect,
  input  wire logic [DATA_W-1:0] portBDataIn,
  input  wire logic              offsetSelectHiSerialEnable,
  input  wire logic              offsetSelectLoSerialData,
  input  wire logic              readFromMarker,
  input  wire logic              retransmitModeSelect,
  output logic      [DATA_W-1:0] portADataOut,
  output logic                   portADataOe,
  output logic      [DATA_W-1:0] portBDataOut,
  output logic                   portBDataOe,
  output logic                   inputReadyFlag,
  output logic                   outputReadyFlag,
  output logic                   almostEmptyFlagN,
  output logic                   almostFullFlagN,
  output logic                   mailboxOneFullN,
  output logic                   mailboxTwoFullN
);
  localparam int         OFS_W    = $clog2(DEPTH);
  localparam int         SER_BITS = 2 * OFS_W;
  localparam int         ICNT_W   = $clog2(SER_BITS + 1);
  localparam int         BCNT_W   = $clog2(BUF_DEPTH + 1);
  localparam int         CMP_W    = OFS_W + 2;
  localparam int         SYNC_W   = 15 + 2 * DATA_W;
  localparam logic [1:0] OR_LAST  = 2'(OR_EDGES - 1);
  localparam logic [ICNT_W-1:0] IR_LAST  = ICNT_W'(IR_EDGES - 1);
  localparam logic [ICNT_W-1:0] SER_LAST = ICNT_W'(SER_BITS - 1);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] syncLvl, syncRise;
  sfr_sync #(.W(SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pinIn   ({portAClock, portBClock, resetPinN, offsetSelectHiSerialEnable,
                offsetSelectLoSerialData, readFromMarker, retransmitModeSelect,
                portASelectN, portAEnable, portAWriteReadSelect, portAMailboxSelect,
                portBSelectN, portBEnable, portBWriteReadSelect, portBMailboxSelect,
                portADataIn, portBDataIn}),
    .lvlOut  (syncLvl),
    .riseOut (syncRise)
  );

  localparam int TOP = SYNC_W - 1;
  wire               aEdge   = syncRise[TOP];
  wire               bEdge   = syncRise[TOP-1];
  wire               rstNLvl = syncLvl[TOP-2];
  wire               rstRise = syncRise[TOP-2];
  wire               senLvl  = syncLvl[TOP-3];
  wire               sdLvl   = syncLvl[TOP-4];
  wire               rfmLvl  = syncLvl[TOP-5];
  wire               rtmLvl  = syncLvl[TOP-6];
  sfr_port_ctl_t     ctlA, ctlB;
  assign ctlA = syncLvl[TOP-7 -: 4];
  assign ctlB = syncLvl[TOP-11 -: 4];
  wire  [DATA_W-1:0] aData   = syncLvl[2*DATA_W-1 -: DATA_W];
  wire  [DATA_W-1:0] bData   = syncLvl[DATA_W-1:0];

  // Pin reset acts only after it has been synchronised
  wire devRst = sys_rst | ~rstNLvl;

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  wire aAct  = aEdge & ~ctlA.selN & ctlA.en;
  wire aWr   = aAct & ctlA.wrSel;
  wire aRd   = aAct & ~ctlA.wrSel;
  wire bAct  = bEdge & ~ctlB.selN & ctlB.en;
  wire bWr   = bAct & ~ctlB.wrSel;
  wire bRd   = bAct & ctlB.wrSel;
  wire mb1Wr = aWr & ctlA.mbx;
  wire mb2Rd = aRd & ctlA.mbx;
  wire mb2Wr = bWr & ctlB.mbx;
  wire mb1Rd = bRd & ctlB.mbx;

  // ----------------------------------------------------------------
  // Offset programming and start-up sequence
  // ----------------------------------------------------------------
  sfr_init_t         initSt_q, initSt_d;
  logic [ICNT_W-1:0] initCnt_q, initCnt_d;
  logic [1:0]        fsSel_q;
  logic [1:0]        parCnt_q;
  logic [OFS_W-1:0]  ofsX_q, ofsY_q;
  logic              irFlag_q;

  wire serShift = (initSt_q == INIT_SERIAL) & aEdge & ~senLvl;
  wire parLoad  = (fsSel_q == FS_PARALLEL) & (parCnt_q != 2'(PAR_LOADS));
  wire fifoWr   = aWr & ~ctlA.mbx & irFlag_q;
  wire ofsWr    = fifoWr & parLoad;

  always_comb begin
    initSt_d  = initSt_q;
    initCnt_d = initCnt_q;
    unique case (initSt_q)
      INIT_RESET: begin
        initCnt_d = '0;
        if (rstRise) begin
          initSt_d = (syncLvl[TOP-3 -: 2] == FS_SERIAL) ? INIT_SERIAL : INIT_WAIT;
        end
      end
      INIT_WAIT: begin
        if (aEdge) begin
          initCnt_d = initCnt_q + ICNT_W'(1);
          if (initCnt_q == IR_LAST) begin
            initSt_d = INIT_RUN;
          end
        end
      end
      INIT_SERIAL: begin
        if (serShift) begin
          initCnt_d = initCnt_q + ICNT_W'(1);
          if (initCnt_q == SER_LAST) begin
            // One more port-A edge then completes the sequence
            initSt_d  = INIT_WAIT;
            initCnt_d = IR_LAST;
          end
        end
      end
      INIT_RUN: begin
        initCnt_d = initCnt_q;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (devRst) begin
      initSt_q  <= INIT_RESET;
      initCnt_q <= '0;
    end else begin
      initSt_q  <= initSt_d;
      initCnt_q <= initCnt_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fsSel_q <= FS_PARALLEL;
      ofsX_q  <= '0;
      ofsY_q  <= '0;
    end else if (rstRise) begin
      fsSel_q <= syncLvl[TOP-3 -: 2];
      if (syncLvl[TOP-3 -: 2] == FS_PRESET64) begin
        ofsX_q <= OFS_W'(PRESET_HI);
        ofsY_q <= OFS_W'(PRESET_HI);
      end else if (syncLvl[TOP-3 -: 2] == FS_PRESET8) begin
        ofsX_q <= OFS_W'(PRESET_LO);
        ofsY_q <= OFS_W'(PRESET_LO);
      end
    end else if (serShift) begin
      {ofsY_q, ofsX_q} <= {ofsY_q[OFS_W-2:0], ofsX_q, sdLvl};
    end else if (ofsWr && parCnt_q == 2'h0) begin
      ofsY_q <= OFS_W'(aData[PAR_OFS_MSB:0]);
    end else if (ofsWr) begin
      ofsX_q <= OFS_W'(aData[PAR_OFS_MSB:0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (devRst) begin
      parCnt_q <= 2'h0;
    end else if (ofsWr) begin
      parCnt_q <= parCnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Buffer and output register
  // ----------------------------------------------------------------
  logic              bufInReady, bufOutValid;
  logic [DATA_W-1:0] bufOutData, bufMarkData, outReg_q;
  logic [BCNT_W-1:0] bufCount;
  logic [1:0]        orCnt_q;
  logic              orFlag_q, retx_q;

  wire rewind  = bEdge & rfmLvl & retx_q;
  wire markSet = bEdge & rtmLvl & orFlag_q & ~retx_q;
  wire markClr = bEdge & ~rtmLvl;
  // A word entering empty memory waits out the synchronising edges
  wire orLoad  = ~orFlag_q & bEdge & bufOutValid & (orCnt_q == OR_LAST);
  wire bFifoRd = bRd & ~ctlB.mbx & orFlag_q;
  wire pop     = orLoad | (bFifoRd & ~rewind);

  sfr_buffer #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
    .ref_clk  (ref_clk),
    .rst      (devRst),
    .inValid  (fifoWr & ~parLoad),
    .inReady  (bufInReady),
    .inData   (aData),
    .outValid (bufOutValid),
    .outReady (pop),
    .outData  (bufOutData),
    .markSet  (markSet),
    .markClr  (markClr),
    .rewind   (rewind),
    .markData (bufMarkData),
    .count    (bufCount)
  );

  always_ff @(posedge ref_clk) begin
    if (devRst) begin
      orFlag_q <= 1'b0;
      orCnt_q  <= 2'h0;
      outReg_q <= '0;
      retx_q   <= 1'b0;
    end else begin
      if (markSet) begin
        retx_q <= 1'b1;
      end else if (markClr) begin
        retx_q <= 1'b0;
      end
      if (rewind) begin
        outReg_q <= bufMarkData;
        orFlag_q <= 1'b1;
      end else if (orLoad || (bFifoRd && bufOutValid)) begin
        outReg_q <= bufOutData;
        orFlag_q <= 1'b1;
      end else if (bFifoRd) begin
        orFlag_q <= 1'b0;
      end
      if (orFlag_q || !bufOutValid) begin
        orCnt_q <= 2'h0;
      end else if (bEdge) begin
        orCnt_q <= orCnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, mailboxes and data outputs
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mail1_q, mail2_q, aOut_q, bOut_q;
  logic              aOe_q, bOe_q, aeN_q, afN_q, mb1N_q, mb2N_q;
  wire  [CMP_W-1:0]  words = CMP_W'(bufCount) + CMP_W'(orFlag_q);
  wire               aeN_d = words > CMP_W'(ofsX_q);
  wire               afN_d = (words + CMP_W'(ofsY_q)) < CMP_W'(BUF_DEPTH);

  always_ff @(posedge ref_clk) begin
    if (devRst) begin
      irFlag_q <= 1'b0;
      aeN_q    <= 1'b0;
      afN_q    <= 1'b1;
      mb1N_q   <= 1'b1;
      mb2N_q   <= 1'b1;
      mail1_q  <= '0;
      mail2_q  <= '0;
    end else begin
      if (aEdge) begin
        irFlag_q <= (initSt_d == INIT_RUN) & bufInReady;
        afN_q    <= afN_d;
      end
      if (bEdge) begin
        aeN_q <= aeN_d;
      end
      // Setting a flag low wins over a same-cycle read
      if (mb1Wr) begin
        mail1_q <= aData;
        mb1N_q  <= 1'b0;
      end else if (mb1Rd) begin
        mb1N_q <= 1'b1;
      end
      if (mb2Wr) begin
        mail2_q <= bData;
        mb2N_q  <= 1'b0;
      end else if (mb2Rd) begin
        mb2N_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aOut_q <= '0;
      bOut_q <= '0;
      aOe_q  <= 1'b0;
      bOe_q  <= 1'b0;
    end else begin
      aOut_q <= mail2_q;
      bOut_q <= ctlB.mbx ? mail1_q : outReg_q;
      aOe_q  <= ~ctlA.selN & ~ctlA.wrSel;
      bOe_q  <= ~ctlB.selN & ctlB.wrSel;
    end
  end

  assign portADataOut     = aOut_q;
  assign portADataOe      = aOe_q;
  assign portBDataOut     = bOut_q;
  assign portBDataOe      = bOe_q;
  assign inputReadyFlag   = irFlag_q;
  assign outputReadyFlag  = orFlag_q;
  assign almostEmptyFlagN = aeN_q;
  assign almostFullFlagN  = afN_q;
  assign mailboxOneFullN  = mb1N_q;
  assign mailboxTwoFullN  = mb2N_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_mbx2_write_low: assert property (mb2Wr && !devRst |=> !mailboxTwoFullN)
    else $error("mailbox-2 flag not low after write");
  a_mbx2_read_high: assert property (mb2Rd && !mb2Wr |=> mailboxTwoFullN)
    else $error("mailbox-2 flag not high after read");
  a_mbx2_reset: assert property (devRst |=> mailboxTwoFullN)
    else $error("mailbox-2 flag not high after reset");
  a_or_ignore_read: assert property (
    !orFlag_q && !orLoad && !rewind && !devRst |=> $stable(outReg_q))
    else $error("output register changed while empty");
  a_or_third_edge: assert property (
    $rose(outputReadyFlag) && !$past(rewind) |-> $past(orCnt_q) == OR_LAST)
    else $error("output-ready rose on wrong edge");
  a_rewind_word: assert property (
    rewind && !devRst |=> outReg_q == $past(bufMarkData) && outputReadyFlag)
    else $error("marked word not presented");
  a_mark_enter: assert property (markSet && !devRst |=> retx_q)
    else $error("retransmit mode not entered");
  a_mark_leave: assert property (markClr && !markSet |=> !retx_q)
    else $error("retransmit mode not left");
  a_porta_float: assert property (ctlA.wrSel |=> !portADataOe)
    else $error("port A drives during write select");
  a_portb_float: assert property (!ctlB.wrSel |=> !portBDataOe)
    else $error("port B drives during write select");
  a_reset_flags: assert property (devRst |=> !inputReadyFlag
    && !outputReadyFlag && !almostEmptyFlagN && almostFullFlagN)
    else $error("reset flag values wrong");
  a_ir_serial_hold: assert property (initSt_q == INIT_SERIAL |-> !inputReadyFlag)
    else $error("input-ready high during serial load");
endmodule : sfr_core

// File: core/sfr_pkg.sv
// Shared constants and types of the offset-programmable retransmit FIFO
package sfr_pkg;

  // ----------------------------------------------------------------
  // Widths and timing counts
  // ----------------------------------------------------------------
  localparam int DATA_W      = 36;
  localparam int SYNC_STAGES = 3;
  localparam int OR_EDGES    = 3;
  localparam int IR_EDGES    = 2;
  localparam int PAR_LOADS   = 2;
  localparam int PAR_OFS_MSB = 10;

  // ----------------------------------------------------------------
  // Offset programming selection, {hi, lo} latched at reset release
  // ----------------------------------------------------------------
  localparam logic [1:0] FS_SERIAL   = 2'h3;
  localparam logic [1:0] FS_PRESET64 = 2'h2;
  localparam logic [1:0] FS_PRESET8  = 2'h1;
  localparam logic [1:0] FS_PARALLEL = 2'h0;
  localparam int         PRESET_HI   = 64;
  localparam int         PRESET_LO   = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic selN;
    logic en;
    logic wrSel;
    logic mbx;
  } sfr_port_ctl_t;

  typedef enum {INIT_RESET, INIT_WAIT, INIT_SERIAL, INIT_RUN} sfr_init_t;

endpackage : sfr_pkg

// File: bench/sfr_port_clocks.sv
// Bus-master side model: free-running port clocks facing the FIFO
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Port clock source
// ------------------------------------------------------------------
module sfr_port_clocks (
  input  wire logic ref_clk,
  output logic      portAClock,
  output logic      portBClock
);
  // Complementary clocks, B half a period behind A: fixed phase keeps
  // every flag latency exact, at the cost of no phase sweep
  logic [2:0] phase_q = 3'h0;

  always_ff @(posedge ref_clk) begin
    phase_q <= phase_q + 3'h1;
  end

  assign portAClock = ~phase_q[2];
  assign portBClock = phase_q[2];
endmodule : sfr_port_clocks

// File: bench/sfr_core_tb.sv
// Self-checking bench of the retransmit FIFO control block
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Bench top
// ------------------------------------------------------------------
module sfr_core_tb import sfr_pkg::*; ;
  logic              ref_clk   = 1'b0;
  logic              sys_rst   = 1'b1;
  logic              resetPinN = 1'b0;
  logic              portAClock;
  logic              portBClock;
  sfr_port_ctl_t     ctlA      = 4'h8;
  sfr_port_ctl_t     ctlB      = 4'h8;
  logic [DATA_W-1:0] dataA     = '0;
  logic [DATA_W-1:0] dataB     = '0;
  logic              fsHi      = 1'b0;
  logic              fsLo      = 1'b0;
  logic              read_from_marker       = 1'b0;
  logic              retransmit_mode_select       = 1'b0;
  logic [17:0]       serBits   = {9'h010, 9'h100};
  logic [DATA_W-1:0] outA;
  logic [DATA_W-1:0] outB;
  logic              oeA, oeB, irF, orF, aeN, afN, mb1N, mb2N;
  int                numErrors = 0;
  int                samplesChecked = 0;

  always #12.5 ref_clk = ~ref_clk;

  sfr_port_clocks partner (.ref_clk(ref_clk), .portAClock(portAClock), .portBClock(portBClock));

  sfr_core #(.DEPTH(512), .BUF_DEPTH(16)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .resetPinN(resetPinN),
    .portAClock(portAClock), .portBClock(portBClock),
    .portASelectN(ctlA.selN), .portAEnable(ctlA.en), .portAWriteReadSelect(ctlA.wrSel),
    .portAMailboxSelect(ctlA.mbx), .portADataIn(dataA),
    .portBSelectN(ctlB.selN), .portBEnable(ctlB.en), .portBWriteReadSelect(ctlB.wrSel),
    .portBMailboxSelect(ctlB.mbx), .portBDataIn(dataB),
    .offsetSelectHiSerialEnable(fsHi), .offsetSelectLoSerialData(fsLo),
    .readFromMarker(read_from_marker), .retransmitModeSelect(retransmit_mode_select),
    .portADataOut(outA), .portADataOe(oeA), .portBDataOut(outB), .portBDataOe(oeB),
    .inputReadyFlag(irF), .outputReadyFlag(orF), .almostEmptyFlagN(aeN),
    .almostFullFlagN(afN), .mailboxOneFullN(mb1N), .mailboxTwoFullN(mb2N));

  task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : chk

  // Controls change at a falling port clock and are held over the rise
  task automatic opA(input logic wr, mbx, input logic [DATA_W-1:0] d);
    @(negedge portAClock);
    ctlA  <= '{1'b0, 1'b1, wr, mbx};
    dataA <= d;
    @(negedge portAClock);
    ctlA.en <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : opA

  task automatic opB(input logic wr, mbx, mark, input logic [DATA_W-1:0] d);
    @(negedge portBClock);
    ctlB  <= '{1'b0, 1'b1, wr, mbx};
    dataB <= d;
    read_from_marker   <= mark;
    @(negedge portBClock);
    ctlB.en <= 1'b0;
    read_from_marker     <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : opB

  task automatic rstDev(input logic [1:0] fs, input logic irExp);
    @(negedge portAClock);
    resetPinN    <= 1'b0;
    {fsHi, fsLo} <= fs;
    repeat (6) @(negedge portAClock);
    chk(1'b0, irF);
    chk(1'b0, orF);
    chk(1'b0, aeN);
    chk(1'b1, afN);
    chk(1'b1, mb1N);
    chk(1'b1, mb2N);
    resetPinN <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk(1'b0, irF);
    repeat (8) @(posedge ref_clk);
    chk(irExp, irF);
  endtask : rstDev

  task automatic wrapUp();
    $display("Comparisons: %0d, mismatches: %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrapUp

  // Limit is about ten times the length of the planned sequence
  initial begin
    repeat (8000) @(posedge ref_clk);
    numErrors++;
    wrapUp();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rstDev(FS_PARALLEL, 1'b1);
    opA(1'b1, 1'b0, 36'hABCDEF00D);
    opA(1'b1, 1'b0, 36'h123456002);
    opA(1'b1, 1'b0, 36'h111111111);
    repeat (14) @(posedge ref_clk);
    chk(1'b0, orF);
    repeat (6) @(posedge ref_clk);
    chk(1'b1, orF);
    chk(36'h111111111, outB);
    opA(1'b1, 1'b0, 36'h222222222);
    opA(1'b1, 1'b0, 36'h333333333);
    repeat (6) @(posedge ref_clk);
    chk(1'b0, afN);
    chk(1'b1, aeN);
    opB(1'b1, 1'b0, 1'b0, '0);
    chk(36'h222222222, outB);
    chk(1'b1, oeB);
    @(negedge portBClock);
    retransmit_mode_select <= 1'b1;
    opB(1'b1, 1'b0, 1'b0, '0);
    chk(36'h333333333, outB);
    opB(1'b1, 1'b0, 1'b0, '0);
    chk(1'b0, orF);
    opB(1'b0, 1'b0, 1'b1, '0);
    chk(36'h222222222, outB);
    chk(1'b1, orF);
    chk(1'b0, oeB);
    opB(1'b1, 1'b0, 1'b0, '0);
    chk(36'h333333333, outB);
    @(negedge portBClock);
    retransmit_mode_select <= 1'b0;
    opB(1'b0, 1'b0, 1'b1, '0);
    chk(36'h333333333, outB);
    opA(1'b1, 1'b1, 36'h444444444);
    chk(1'b0, mb1N);
    chk(1'b0, oeA);
    opB(1'b1, 1'b1, 1'b0, '0);
    chk(36'h444444444, outB);
    chk(1'b1, mb1N);
    opB(1'b0, 1'b1, 1'b0, 36'h555555555);
    chk(1'b0, mb2N);
    opA(1'b0, 1'b1, '0);
    chk(36'h555555555, outA);
    chk(1'b1, mb2N);
    chk(1'b1, oeA);
    opB(1'b0, 1'b1, 1'b0, 36'h666666666);
    rstDev(FS_PRESET64, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk(1'b0, afN);
    rstDev(FS_PRESET8, 1'b1);
    repeat (8) @(posedge ref_clk);
    chk(1'b1, afN);
    rstDev(FS_SERIAL, 1'b0);
    for (int i = 17; i >= 0; i--) begin
      @(negedge portAClock);
      fsHi <= 1'b0;
      fsLo <= serBits[i];
    end
    @(negedge portAClock);
    fsHi <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(1'b0, irF);
    repeat (8) @(posedge ref_clk);
    chk(1'b1, irF);
    repeat (8) @(posedge ref_clk);
    chk(1'b0, afN);
    wrapUp();
  end
endmodule : sfr_core_tb
